// ### core/riesq_defines.svh
`ifndef RIESQ_DEFINES_SVH
`define RIESQ_DEFINES_SVH

// Working register map, index into the copied configuration
`define RIESQ_NUM_ENTRIES   4
`define RIESQ_IDX_W         2
`define RIESQ_IDX_I2C_BASE  2'h0
`define RIESQ_IDX_PMB_BASE  2'h1
`define RIESQ_IDX_EN_CFG    2'h2
`define RIESQ_IDX_SPARE     2'h3

// Enable configuration fields
`define RIESQ_EN_SW_MODE_BIT 0
`define RIESQ_EN_SW_ON_BIT   1

// Stored defaults held in the nonvolatile store
`define RIESQ_DEF_I2C_BASE  8'h10
`define RIESQ_DEF_PMB_BASE  8'h40
`define RIESQ_DEF_EN_CFG    8'h00
`define RIESQ_DEF_SPARE     8'h00

// Address offset field of the ten-bit converter code
`define RIESQ_ADC_W         10
`define RIESQ_OFS_MSB       9
`define RIESQ_OFS_LSB       6

`endif

// ### core/riesq_pkg.sv
`include "riesq_defines.svh"

package riesq_pkg;

   typedef logic [7:0]                  riesq_word_t;
   typedef logic [`RIESQ_IDX_W-1:0]     riesq_idx_t;
   typedef logic [`RIESQ_ADC_W-1:0]     riesq_adc_t;

   typedef enum logic [4:0] {
      ST_POR   = 5'h01,
      ST_LOAD  = 5'h02,
      ST_STORE = 5'h04,
      ST_ADDR  = 5'h08,
      ST_RUN   = 5'h10
   } riesq_state_e;

   typedef struct packed {
      riesq_state_e                          state;
      riesq_idx_t                            idx;
      logic [`RIESQ_NUM_ENTRIES-1:0][7:0]    wreg;
      logic [3:0]                            offset;
      logic                                  addr_read;
      logic                                  conv_en;
   } riesq_regs_s;

endpackage

// ### core/riesq_nv_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "riesq_defines.svh"

module riesq_nv_store #(
   parameter int DEPTH = `RIESQ_NUM_ENTRIES,
   parameter int AW    = `RIESQ_IDX_W
) (
   input  wire logic          clk_i,
   input  wire logic          reset_n_i,
   input  wire logic [AW-1:0] rd_addr_i,
   output logic [7:0]         rd_data_o
);

   // Contents are fixed at build time; programming path lies outside
   function automatic logic [7:0] stored(input logic [AW-1:0] a);
      case (a)
         `RIESQ_IDX_I2C_BASE: stored = `RIESQ_DEF_I2C_BASE;
         `RIESQ_IDX_PMB_BASE: stored = `RIESQ_DEF_PMB_BASE;
         `RIESQ_IDX_EN_CFG:   stored = `RIESQ_DEF_EN_CFG;
         default:             stored = `RIESQ_DEF_SPARE;
      endcase
   endfunction

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= stored(rd_addr_i);
      end
   end

endmodule

`default_nettype wire

// ### core/riesq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "riesq_defines.svh"

// Overview of operation
// - Hold reset until rails and oscillator good
// - After reset, copy every stored entry
// - Accept host writes after load, regardless enable
// - Default enable: pin, bus, load, address
// - Software enable options replace the pin condition only; bus, load, address still gate
// - Separate 7-bit I2C and PMBus bases
// - Zero base address disables that bus
// - Converter code gives offset 0..15 added
// - Floating address pin: analog, ignore commands
module riesq_sequencer (
   input  wire logic               clk_i,
   input  wire logic               reset_n_i,
   input  wire logic               bias_supply_good_i,
   input  wire logic               core_supply_rail_good_i,
   input  wire logic               osc_stable_i,
   input  wire logic               enable_mode_pin_above_i,
   input  wire logic               input_bus_above_uv_i,
   input  wire logic               addr_adc_valid_i,
   input  wire riesq_pkg::riesq_adc_t  addr_adc_code_i,
   input  wire logic               addr_floating_i,
   input  wire logic               host_wr_i,
   input  wire riesq_pkg::riesq_idx_t  host_addr_i,
   input  wire riesq_pkg::riesq_word_t host_wdata_i,
   output logic                    host_wr_ack_o,
   output logic                    por_n_o,
   output logic                    load_done_o,
   output logic                    addr_read_o,
   output logic                    digital_mode_o,
   output logic [6:0]              i2c_addr_o,
   output logic [6:0]              pmbus_addr_o,
   output logic                    i2c_comm_en_o,
   output logic                    pmbus_comm_en_o,
   output logic                    conv_enable_o
);
   import riesq_pkg::*;

   riesq_regs_s r_ff;
   riesq_regs_s nxt_r;
   riesq_word_t mem_rdata;
   logic        pwr_good;
   logic        loaded;
   logic        sw_mode;
   logic        hw_cond;
   logic        sw_cond;
   logic        en_cond;

   function automatic logic [6:0] bus_addr(input logic [6:0] base, input logic [3:0] ofs);
      bus_addr = 7'(base + {3'h0, ofs});
   endfunction

   riesq_nv_store #(
      .DEPTH (`RIESQ_NUM_ENTRIES),
      .AW    (`RIESQ_IDX_W)
   ) u_store (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .rd_addr_i (r_ff.idx),
      .rd_data_o (mem_rdata)
   );

   assign pwr_good = bias_supply_good_i & core_supply_rail_good_i & osc_stable_i;
   assign loaded   = (r_ff.state == ST_ADDR) || (r_ff.state == ST_RUN);
   // Analog mode masks the software mode bit, so the hardware enable conditions apply
   assign sw_mode  = r_ff.wreg[`RIESQ_IDX_EN_CFG][`RIESQ_EN_SW_MODE_BIT] & ~addr_floating_i;
   assign hw_cond  = enable_mode_pin_above_i & input_bus_above_uv_i & loaded & r_ff.addr_read;
   assign sw_cond  = r_ff.wreg[`RIESQ_IDX_EN_CFG][`RIESQ_EN_SW_ON_BIT] & input_bus_above_uv_i
                     & loaded & r_ff.addr_read;
   assign en_cond  = sw_mode ? sw_cond : hw_cond;

   assign host_wr_ack_o = host_wr_i & loaded & ~addr_floating_i;

   always_comb begin
      nxt_r = r_ff;
      unique case (r_ff.state)
         ST_POR: begin
            nxt_r.idx       = '0;
            nxt_r.addr_read = 1'b0;
            if (pwr_good) begin
               nxt_r.state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            nxt_r.state = ST_STORE;
         end
         ST_STORE: begin
            nxt_r.wreg[r_ff.idx] = mem_rdata;
            nxt_r.idx            = riesq_idx_t'(r_ff.idx + 1'b1);
            if (r_ff.idx == riesq_idx_t'(`RIESQ_NUM_ENTRIES - 1)) begin
               nxt_r.state = ST_ADDR;
            end else begin
               nxt_r.state = ST_LOAD;
            end
         end
         ST_ADDR: begin
            if (addr_adc_valid_i) begin
               nxt_r.offset    = addr_adc_code_i[`RIESQ_OFS_MSB:`RIESQ_OFS_LSB];
               nxt_r.addr_read = 1'b1;
               nxt_r.state     = ST_RUN;
            end
         end
         ST_RUN: begin
         end
      endcase
      if (host_wr_ack_o) begin
         nxt_r.wreg[host_addr_i] = host_wdata_i;
      end
      // Continuous re-evaluation; no latching of a once-true enable
      nxt_r.conv_en = en_cond;
      if (!pwr_good) begin
         nxt_r.state     = ST_POR;
         nxt_r.conv_en   = 1'b0;
         nxt_r.addr_read = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r_ff <= '{state: ST_POR, idx: '0, wreg: '0, offset: 4'h0,
                   addr_read: 1'b0, conv_en: 1'b0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign por_n_o        = (r_ff.state != ST_POR);
   assign load_done_o    = loaded;
   assign addr_read_o    = r_ff.addr_read;
   assign digital_mode_o = r_ff.addr_read & ~addr_floating_i;
   assign i2c_addr_o     = bus_addr(r_ff.wreg[`RIESQ_IDX_I2C_BASE][6:0], r_ff.offset);
   assign pmbus_addr_o   = bus_addr(r_ff.wreg[`RIESQ_IDX_PMB_BASE][6:0], r_ff.offset);
   assign i2c_comm_en_o  = digital_mode_o
                           & (r_ff.wreg[`RIESQ_IDX_I2C_BASE][6:0] != 7'h00);
   assign pmbus_comm_en_o = digital_mode_o
                            & (r_ff.wreg[`RIESQ_IDX_PMB_BASE][6:0] != 7'h00);
   assign conv_enable_o  = r_ff.conv_en;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_load_entry;
      r_ff.state == ST_LOAD ##1 r_ff.state == ST_STORE;
   endsequence

   chk_por_hold: assert property (!pwr_good |=> !por_n_o && !conv_enable_o)
      else $error("reset not held while power is bad");
   chk_load_start: assert property ((r_ff.state == ST_POR) && pwr_good |=> s_load_entry)
      else $error("load cycle did not start after reset release");
   chk_load_copy: assert property ((r_ff.state == ST_STORE) && pwr_good && !host_wr_ack_o
      |=> r_ff.wreg[$past(r_ff.idx)] == $past(mem_rdata))
      else $error("stored entry not copied to working register");
   chk_host_write: assert property (host_wr_ack_o && pwr_good
      |=> r_ff.wreg[$past(host_addr_i)] == $past(host_wdata_i))
      else $error("accepted host write not stored");
   chk_hw_gate: assert property (!sw_mode && pwr_good ##1 conv_enable_o
      |-> $past(enable_mode_pin_above_i) && $past(input_bus_above_uv_i) && $past(r_ff.addr_read))
      else $error("conversion enabled without all hardware conditions");
   chk_sw_gate: assert property (sw_mode && pwr_good |=> conv_enable_o == $past(sw_cond))
      else $error("software enable not followed");
   chk_zero_base: assert property (i2c_comm_en_o |-> addr_read_o
      && r_ff.wreg[`RIESQ_IDX_I2C_BASE][6:0] != 7'h00 && !addr_floating_i)
      else $error("I2C enabled with zero base or in analog mode");
   chk_addr_offset: assert property ($rose(r_ff.addr_read)
      |-> r_ff.offset == $past(addr_adc_code_i[`RIESQ_OFS_MSB:`RIESQ_OFS_LSB]))
      else $error("address offset not taken from converter code");
   chk_analog_ignore: assert property (addr_floating_i |-> !host_wr_ack_o && !digital_mode_o)
      else $error("bus command accepted in analog mode");
   chk_enable_drop: assert property (!en_cond |=> !conv_enable_o)
      else $error("enable not removed when a condition failed");

endmodule

`default_nettype wire

// ### dv/riesq_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module riesq_host_model
   import riesq_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              go_i,
   input  wire riesq_pkg::riesq_idx_t  idx_i,
   input  wire riesq_pkg::riesq_word_t data_i,
   input  wire logic              ack_i,
   output logic                   wr_o,
   output riesq_pkg::riesq_idx_t  addr_o,
   output riesq_pkg::riesq_word_t wdata_o,
   output logic                   busy_o,
   output logic                   acked_o
);
   initial begin
      wr_o = 1'b0;
      addr_o = 2'h0;
      wdata_o = 8'h00;
      busy_o = 1'b0;
      acked_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (go_i) begin
            busy_o = 1'b1;
            #1 wr_o = 1'b1;
            addr_o = idx_i;
            wdata_o = data_i;
            acked_o = 1'b0;
            // Refused writes give up early; bound stays below a full load
            repeat (4) begin
               @(posedge clk_i);
               if (ack_i === 1'b1) begin
                  acked_o = 1'b1;
                  break;
               end
            end
            #1 wr_o = 1'b0;
            // Released lines must not look like held data
            addr_o = ~addr_o;
            wdata_o = ~wdata_o;
            busy_o = 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// ### dv/regulator_init_enable_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none

module regulator_init_enable_sequencer_bench;
   import riesq_pkg::*;
   logic clk_i, reset_n_i, bias_supply_good_i, core_supply_rail_good_i, osc_stable_i;
   logic enable_mode_pin_above_i, input_bus_above_uv_i, addr_adc_valid_i, addr_floating_i;
   logic host_wr_i, host_wr_ack_o, por_n_o, load_done_o, addr_read_o, digital_mode_o;
   logic i2c_comm_en_o, pmbus_comm_en_o, conv_enable_o, go, busy, acked;
   logic [6:0]  i2c_addr_o, pmbus_addr_o;
   riesq_adc_t  addr_adc_code_i;
   riesq_idx_t  host_addr_i, idx;
   riesq_word_t host_wdata_i, dat;
   int          errors, samples_checked;

   riesq_sequencer uut (
      .clk_i                   (clk_i),
      .reset_n_i               (reset_n_i),
      .bias_supply_good_i      (bias_supply_good_i),
      .core_supply_rail_good_i (core_supply_rail_good_i),
      .osc_stable_i            (osc_stable_i),
      .enable_mode_pin_above_i (enable_mode_pin_above_i),
      .input_bus_above_uv_i    (input_bus_above_uv_i),
      .addr_adc_valid_i        (addr_adc_valid_i),
      .addr_adc_code_i         (addr_adc_code_i),
      .addr_floating_i         (addr_floating_i),
      .host_wr_i               (host_wr_i),
      .host_addr_i             (host_addr_i),
      .host_wdata_i            (host_wdata_i),
      .host_wr_ack_o           (host_wr_ack_o),
      .por_n_o                 (por_n_o),
      .load_done_o             (load_done_o),
      .addr_read_o             (addr_read_o),
      .digital_mode_o          (digital_mode_o),
      .i2c_addr_o              (i2c_addr_o),
      .pmbus_addr_o            (pmbus_addr_o),
      .i2c_comm_en_o           (i2c_comm_en_o),
      .pmbus_comm_en_o         (pmbus_comm_en_o),
      .conv_enable_o           (conv_enable_o)
   );
   riesq_host_model host (.clk_i(clk_i), .go_i(go), .idx_i(idx), .data_i(dat),
      .ack_i(host_wr_ack_o), .wr_o(host_wr_i), .addr_o(host_addr_i),
      .wdata_o(host_wdata_i), .busy_o(busy), .acked_o(acked));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic wrap_up();
      if (errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic hw(input riesq_idx_t i, input riesq_word_t d, input logic ok);
      int n;
      idx = i;
      dat = d;
      go = 1'b1;
      step(1);
      go = 1'b0;
      for (n = 0; n < 20 && busy !== 1'b0; n++) step(1);
      if (n == 20) begin
         errors++;
         wrap_up();
      end
      chk(acked, ok);
      step(1);
   endtask

   task automatic t_power();
      bias_supply_good_i = 1'b1;
      core_supply_rail_good_i = 1'b1;
      step(20);
      chk(por_n_o, 1'b0);
      osc_stable_i = 1'b1;
      step(2);
      chk(por_n_o, 1'b1);
      hw(2'h0, 8'h55, 1'b0);
      step(1);
      chk(load_done_o, 1'b1);
      chk({1'b0, i2c_addr_o}, 8'h10);
      chk({1'b0, pmbus_addr_o}, 8'h40);
      chk(conv_enable_o, 1'b0);
   endtask

   task automatic t_addr();
      enable_mode_pin_above_i = 1'b1;
      input_bus_above_uv_i = 1'b1;
      addr_adc_code_i = 10'h3c0;
      addr_adc_valid_i = 1'b1;
      step(1);
      chk(addr_read_o, 1'b1);
      chk({1'b0, i2c_addr_o}, 8'h1f);
      chk({1'b0, pmbus_addr_o}, 8'h4f);
      step(1);
      chk(conv_enable_o, 1'b1);
      enable_mode_pin_above_i = 1'b0;
      step(1);
      chk(conv_enable_o, 1'b0);
   endtask

   task automatic t_host();
      hw(2'h0, 8'h00, 1'b1);
      chk(i2c_comm_en_o, 1'b0);
      chk(pmbus_comm_en_o, 1'b1);
      hw(2'h2, 8'h03, 1'b1);
      step(1);
      chk(conv_enable_o, 1'b1);
   endtask

   task automatic t_float();
      addr_floating_i = 1'b1;
      enable_mode_pin_above_i = 1'b1;
      step(2);
      chk(digital_mode_o, 1'b0);
      chk(pmbus_comm_en_o, 1'b0);
      hw(2'h1, 8'h00, 1'b0);
      chk({1'b0, pmbus_addr_o}, 8'h4f);
      chk(conv_enable_o, 1'b1);
      osc_stable_i = 1'b0;
      step(1);
      chk(por_n_o, 1'b0);
      chk(conv_enable_o, 1'b0);
   endtask

   initial begin
      {bias_supply_good_i, core_supply_rail_good_i, osc_stable_i, go} = 4'h0;
      {enable_mode_pin_above_i, input_bus_above_uv_i, addr_adc_valid_i} = 3'h0;
      addr_floating_i = 1'b0;
      addr_adc_code_i = 10'h000;
      idx = 2'h0;
      dat = 8'h00;
      errors = 0;
      samples_checked = 0;
      reset_n_i = 1'b0;
      step(16);
      reset_n_i = 1'b1;
      t_power();
      t_addr();
      t_host();
      t_float();
      wrap_up();
   end
endmodule

`default_nettype wire
